// file: design/channel_adapter_selection.sv
`timescale 1ns/100ps
module channel_adapter_selection (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Driver register port
  input wire chan_adapter_pkg::reg_req_s regReq,
  output logic [7:0] regRdata,
  // Channel lines and straps
  input wire chan_adapter_pkg::chan_in_s chanIn,
  output chan_adapter_pkg::chan_out_s chanOut,
  // Front panel
  output logic onlineLamp
);

  // Whole state of the block
  typedef struct packed {
    chan_adapter_pkg::chan_in_s s1;         // First synchroniser stage
    chan_adapter_pkg::chan_in_s s2;         // Second synchroniser stage
    chan_adapter_pkg::sel_state_e st;       // Selection sequencer state
    logic [3:0] lbi;                        // Matched logical_buffer_index
    logic [7:0] cmd;                        // Captured channel command
    logic cmdParErr;                        // Command arrived with bad parity
    logic [3:0] aux;                        // Buffer chosen by the driver
    logic [3:0] ctrlIdx;                    // Control byte chosen by the driver
    logic [7:0] aaAddr;                     // Address RAM write pointer
    logic busy;                             // Host command being taken
    logic online;                           // Online and configured
    logic onPend;                           // Online request waiting
    logic offPend;                          // Offline request waiting
    logic initReq;                          // Initiate sequence waiting
    chan_adapter_pkg::lb_state_e [15:0] lbState; // Per-buffer state
    logic [15:0] stacked;                   // Initial status stacked
    logic [15:0] seqPend;                   // Sequence waiting for service
    logic [15:0] endDev;                    // Sequence ends with device end
    logic [3:0] grant;                      // Buffer last served
    logic granted;                          // A slice is running
    logic [2:0] slot;                       // Bytes left in the slice
    logic [4:0] wrPtr;                      // Activity FIFO write pointer
    logic [4:0] rdPtr;                      // Activity FIFO read pointer
    logic [7:0] rdata;                      // Register read data
    chan_adapter_pkg::chan_out_s out;       // Channel outbound lines
    logic lamp;                             // Online indicator
  } state_s;

  state_s q;
  state_s n;

  // Memory ports
  logic ctrlWe;
  logic [7:0] ctrlWaddr;
  logic [7:0] ctrlWdata;
  logic [7:0] ctrlRaddr;
  logic [7:0] ctrlRdata;
  logic aaWe;
  logic [7:0] aaRdata;
  logic fifoWe;
  logic [3:0] fifoRdata;

  // Decode helpers
  logic selArr;
  logic match;
  logic fifoEmpty;
  logic fifoFull;
  logic notify;

  // Next buffer with a pending sequence after the last one served
  function automatic logic [3:0] nextPend(input logic [15:0] pend, input logic [3:0] last);
    logic [3:0] idx;
    logic [3:0] pick;
    logic found;
    pick = last;
    found = 1'b0;
    for (int i = 1; i <= 16; i++) begin
      idx = last + i[3:0];
      if (!found && pend[idx]) begin
        pick = idx;
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  // True while any buffer is awaiting service or busy
  function automatic logic anyLive(input chan_adapter_pkg::lb_state_e [15:0] s);
    logic live;
    live = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (s[i] == chan_adapter_pkg::LB_SERVICE || s[i] == chan_adapter_pkg::LB_ACTIVITY) begin
        live = 1'b1;
      end
    end
    return live;
  endfunction

  // Control buffers: sixteen buffers of sixteen bytes
  buffer_ram #(.W(8), .A(8)) ctrlRam (
    .clk(clk),
    .we(ctrlWe),
    .waddr(ctrlWaddr),
    .wdata(ctrlWdata),
    .raddr(ctrlRaddr),
    .rdata(ctrlRdata)
  );

  // Active address RAM indexed by the channel address
  buffer_ram #(.W(8), .A(8)) aaRam (
    .clk(clk),
    .we(aaWe),
    .waddr(q.aaAddr),
    .wdata(regReq.wdata),
    .raddr(q.s2.busOut),
    .rdata(aaRdata)
  );

  // Activity FIFO of buffer indices
  buffer_ram #(.W(4), .A(4)) fifoRam (
    .clk(clk),
    .we(fifoWe),
    .waddr(q.wrPtr[3:0]),
    .wdata(q.lbi),
    .raddr(q.rdPtr[3:0]),
    .rdata(fifoRdata)
  );

  // Next-state logic
  always_comb begin
    n = q;
    ctrlWe = 1'b0;
    ctrlWaddr = {q.aux, q.ctrlIdx};
    ctrlWdata = regReq.wdata;
    ctrlRaddr = {q.aux, q.ctrlIdx};
    aaWe = 1'b0;
    fifoWe = 1'b0;
    n.rdata = 8'h00;

    // Two-stage synchroniser on every inbound line
    n.s1 = chanIn;
    n.s2 = q.s1;

    // Incoming select follows the priority strap
    selArr = q.s2.priorityStrap ? q.s2.selectIn : q.s2.selectOut;
    // Match needs the RAM flag and good parity
    match = q.online && q.s2.addressOut && aaRdata[chan_adapter_pkg::AA_MATCH]
      && chan_adapter_pkg::parOk(q.s2.busOut, q.s2.busOutPar);
    fifoEmpty = (q.wrPtr == q.rdPtr);
    fifoFull = (q.wrPtr[4] != q.rdPtr[4]) && (q.wrPtr[3:0] == q.rdPtr[3:0]);
    notify = 1'b0;

    // Busy drops once no online or initiate command is outstanding, a waiting offline does not hold it
    if (q.busy && !q.onPend && !q.initReq) begin
      n.busy = 1'b0;
    end

    // Register writes
    if (regReq.write) begin
      case (regReq.addr)
        chan_adapter_pkg::REG_HOST_CMD: begin
          n.busy = 1'b1;
          case (regReq.wdata[2:0])
            chan_adapter_pkg::HC_ONLINE: begin
              n.onPend = 1'b1;
            end
            chan_adapter_pkg::HC_OFFLINE: begin
              n.offPend = 1'b1;
            end
            chan_adapter_pkg::HC_INITIATE: begin
              n.initReq = 1'b1;
            end
            default: begin
              n.busy = 1'b1;
            end
          endcase
        end
        chan_adapter_pkg::REG_AUX: begin
          n.aux = regReq.wdata[3:0];
        end
        chan_adapter_pkg::REG_CTRL_IDX: begin
          n.ctrlIdx = regReq.wdata[3:0];
        end
        chan_adapter_pkg::REG_CTRL_DATA: begin
          ctrlWe = 1'b1;
        end
        chan_adapter_pkg::REG_AA_ADDR: begin
          n.aaAddr = regReq.wdata;
        end
        chan_adapter_pkg::REG_AA_DATA: begin
          // Address RAM only changes while offline
          if (!q.online) begin
            aaWe = 1'b1;
            if (regReq.wdata[chan_adapter_pkg::AA_MATCH]) begin
              n.lbState[regReq.wdata[3:0]] = chan_adapter_pkg::LB_ACTIVE;
            end
          end
        end
        default: begin
          n.aux = q.aux;
        end
      endcase
    end

    // Register reads, data stand one cycle later
    if (regReq.read) begin
      case (regReq.addr)
        chan_adapter_pkg::REG_STATUS: begin
          n.rdata[chan_adapter_pkg::ST_BUSY] = q.busy;
          n.rdata[chan_adapter_pkg::ST_ONLINE] = q.online;
          n.rdata[chan_adapter_pkg::ST_ADDR_AVAIL] = !fifoEmpty;
          n.rdata[chan_adapter_pkg::ST_OFF_PEND] = q.offPend;
        end
        chan_adapter_pkg::REG_AUX: begin
          n.rdata = {4'h0, q.aux};
        end
        chan_adapter_pkg::REG_FIFO: begin
          // Reading pops the head, bit 7 marks a valid entry
          if (!fifoEmpty) begin
            n.rdata = {1'b1, 3'h0, fifoRdata};
            n.rdPtr = q.rdPtr + 5'h01;
          end
        end
        chan_adapter_pkg::REG_CTRL_IDX: begin
          n.rdata = {4'h0, q.ctrlIdx};
        end
        chan_adapter_pkg::REG_CTRL_DATA: begin
          n.rdata = ctrlRdata;
        end
        chan_adapter_pkg::REG_AA_ADDR: begin
          n.rdata = q.aaAddr;
        end
        chan_adapter_pkg::REG_LB_STATE: begin
          n.rdata = {6'h00, q.lbState[q.aux]};
        end
        default: begin
          n.rdata = 8'h00;
        end
      endcase
    end

    // Online waits for stop/wait state, or the simulator in test mode
    if (q.onPend && (q.s2.testMode ? q.s2.simReady : q.s2.cpuStopped)) begin
      n.online = 1'b1;
      n.onPend = 1'b0;
    end

    // Offline deferred until every buffer is idle
    if (q.offPend && !anyLive(q.lbState) && q.st == chan_adapter_pkg::SEL_IDLE) begin
      n.online = 1'b0;
      n.offPend = 1'b0;
    end
    n.lamp = n.online;

    // Round-robin slices among buffers with running sequences
    if (q.granted) begin
      if (q.slot <= 3'h1) begin
        // Slice over: device end frees the buffer, else back to service
        n.granted = 1'b0;
        n.seqPend[q.grant] = 1'b0;
        n.lbState[q.grant] = q.endDev[q.grant] ? chan_adapter_pkg::LB_ACTIVE
          : chan_adapter_pkg::LB_SERVICE;
      end else begin
        n.slot = q.slot - 3'h1;
      end
    end else if (|q.seqPend) begin
      n.grant = nextPend(q.seqPend, q.grant);
      n.granted = 1'b1;
      n.slot = q.s2.oneByteMode ? chan_adapter_pkg::QUOTA_ONE : chan_adapter_pkg::QUOTA_FOUR;
    end

    // Selection sequencer
    case (q.st)
      chan_adapter_pkg::SEL_IDLE: begin
        // Pass the select unless one of our addresses matched
        n.out.selectPass = selArr && !match;
        if (match && selArr) begin
          n.lbi = aaRdata[3:0];
          n.out.selectPass = 1'b0;
          n.out.operationalIn = 1'b1;
          n.st = chan_adapter_pkg::SEL_WT_ADDR_DROP;
        end else if (q.initReq) begin
          ctrlRaddr = {q.aux, chan_adapter_pkg::CB_SEQ_PARAM};
          n.st = chan_adapter_pkg::SEL_PRM_LD;
        end
      end
      chan_adapter_pkg::SEL_PRM_RD: begin
        ctrlRaddr = {q.aux, chan_adapter_pkg::CB_SEQ_PARAM};
        n.st = chan_adapter_pkg::SEL_PRM_LD;
      end
      chan_adapter_pkg::SEL_PRM_LD: begin
        // Only a buffer awaiting service can start a sequence
        if (q.lbState[q.aux] == chan_adapter_pkg::LB_SERVICE) begin
          n.lbState[q.aux] = chan_adapter_pkg::LB_ACTIVITY;
          n.seqPend[q.aux] = 1'b1;
          n.endDev[q.aux] = ctrlRdata[chan_adapter_pkg::SEQ_END_DEV];
        end
        n.initReq = 1'b0;
        n.st = chan_adapter_pkg::SEL_IDLE;
      end
      chan_adapter_pkg::SEL_WT_ADDR_DROP: begin
        if (!q.s2.addressOut) begin
          ctrlRaddr = {q.lbi, chan_adapter_pkg::CB_DEV_ADDR};
          n.st = chan_adapter_pkg::SEL_ADDR_LD;
        end
      end
      chan_adapter_pkg::SEL_ADDR_LD: begin
        n.out.busIn = ctrlRdata;
        n.out.addressIn = 1'b1;
        n.st = chan_adapter_pkg::SEL_WT_CMD;
      end
      chan_adapter_pkg::SEL_WT_CMD: begin
        // Command captured here; test I/O and no-op are not written to the command byte
        if (q.s2.commandOut && !ctrlWe) begin
          n.cmd = q.s2.busOut;
          n.cmdParErr = !chan_adapter_pkg::parOk(q.s2.busOut, q.s2.busOutPar);
          if (q.s2.busOut != chan_adapter_pkg::CMD_TEST_IO && q.s2.busOut != chan_adapter_pkg::CMD_NOP) begin
            ctrlWe = 1'b1;
            ctrlWaddr = {q.lbi, chan_adapter_pkg::CB_COMMAND};
            ctrlWdata = q.s2.busOut;
          end
          n.out.addressIn = 1'b0;
          n.st = chan_adapter_pkg::SEL_WT_CMD_DROP;
        end
      end
      chan_adapter_pkg::SEL_WT_CMD_DROP: begin
        if (!q.s2.commandOut) begin
          if (q.cmd == chan_adapter_pkg::CMD_NOP) begin
            n.out.busIn = chan_adapter_pkg::STAT_CE_DE;
            n.out.statusIn = 1'b1;
            n.st = chan_adapter_pkg::SEL_WT_STAT;
          end else begin
            ctrlRaddr = {q.lbi, chan_adapter_pkg::CB_INIT_STATUS};
            n.st = chan_adapter_pkg::SEL_STAT_LD;
          end
        end
      end
      chan_adapter_pkg::SEL_STAT_LD: begin
        n.out.busIn = ctrlRdata;
        n.out.statusIn = 1'b1;
        n.st = chan_adapter_pkg::SEL_WT_STAT;
      end
      chan_adapter_pkg::SEL_WT_STAT: begin
        notify = (q.cmd != chan_adapter_pkg::CMD_TEST_IO && q.cmd != chan_adapter_pkg::CMD_NOP)
          || (q.cmd == chan_adapter_pkg::CMD_TEST_IO && q.stacked[q.lbi]);
        if (q.s2.serviceOut && !ctrlWe) begin
          // Status accepted
          n.out.statusIn = 1'b0;
          n.stacked[q.lbi] = 1'b0;
          if (notify) begin
            ctrlWe = 1'b1;
            ctrlWaddr = {q.lbi, chan_adapter_pkg::CB_CHAN_CTRL};
            ctrlWdata = 8'h00;
            ctrlWdata[chan_adapter_pkg::CCW_CMD_RECV] = 1'b1;
            ctrlWdata[chan_adapter_pkg::CCW_SEL_OUT] = q.s2.selectOut;
            ctrlWdata[chan_adapter_pkg::CCW_PAR_ERR] = q.cmdParErr;
            n.lbState[q.lbi] = chan_adapter_pkg::LB_SERVICE;
            if (!fifoFull) begin
              fifoWe = 1'b1;
              n.wrPtr = q.wrPtr + 5'h01;
            end
          end
          n.st = chan_adapter_pkg::SEL_FINISH;
        end else if (q.s2.commandOut) begin
          // Status stacked, driver hears nothing yet
          n.out.statusIn = 1'b0;
          n.stacked[q.lbi] = (q.cmd != chan_adapter_pkg::CMD_TEST_IO) || q.stacked[q.lbi];
          n.st = chan_adapter_pkg::SEL_FINISH;
        end
      end
      chan_adapter_pkg::SEL_FINISH: begin
        // Operational in holds while the channel keeps select up
        if (!q.s2.selectOut) begin
          n.out.operationalIn = 1'b0;
          n.st = chan_adapter_pkg::SEL_IDLE;
        end
      end
      default: begin
        n.st = chan_adapter_pkg::SEL_IDLE;
      end
    endcase

    // Parity always follows the inbound bus byte
    n.out.busInPar = chan_adapter_pkg::oddPar(n.out.busIn);
  end

  // State register, all outputs change on the clock edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
      q.st <= chan_adapter_pkg::SEL_IDLE;
      q.out.busInPar <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from the state register
  assign regRdata = q.rdata;
  assign chanOut = q.out;
  assign onlineLamp = q.lamp;

endmodule

// file: design/chan_adapter_pkg.sv
package chan_adapter_pkg;

  // Register offsets on the driver port
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_HOST_CMD = 4'h1;
  localparam logic [3:0] REG_AUX = 4'h2;
  localparam logic [3:0] REG_FIFO = 4'h3;
  localparam logic [3:0] REG_CTRL_IDX = 4'h4;
  localparam logic [3:0] REG_CTRL_DATA = 4'h5;
  localparam logic [3:0] REG_AA_ADDR = 4'h6;
  localparam logic [3:0] REG_AA_DATA = 4'h7;
  localparam logic [3:0] REG_LB_STATE = 4'h8;

  // Status byte bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_ONLINE = 1;
  localparam int ST_ADDR_AVAIL = 2;
  localparam int ST_OFF_PEND = 3;

  // Host command codes (host_command_one)
  localparam logic [2:0] HC_ONLINE = 3'h1;
  localparam logic [2:0] HC_OFFLINE = 3'h2;
  localparam logic [2:0] HC_INITIATE = 3'h3;

  // Control buffer byte indices
  localparam logic [3:0] CB_DEV_ADDR = 4'h0;
  localparam logic [3:0] CB_COMMAND = 4'h1;
  localparam logic [3:0] CB_INIT_STATUS = 4'h2;
  localparam logic [3:0] CB_SEQ_PARAM = 4'h3;
  localparam logic [3:0] CB_CHAN_CTRL = 4'h5;

  // Channel control word bits, sequence parameter bits and address RAM match bit
  localparam int CCW_CMD_RECV = 0;
  localparam int CCW_SEL_OUT = 5;
  localparam int CCW_PAR_ERR = 7;
  localparam int SEQ_END_DEV = 0;
  localparam int AA_MATCH = 7;

  // Channel command and status codes
  localparam logic [7:0] CMD_TEST_IO = 8'h00;
  localparam logic [7:0] CMD_NOP = 8'h03;
  localparam logic [7:0] STAT_CE_DE = 8'h0c;

  // Bytes per multiplexing slice
  localparam logic [2:0] QUOTA_FOUR = 3'h4;
  localparam logic [2:0] QUOTA_ONE = 3'h1;

  // Logical buffer states
  typedef enum logic [1:0] {
    LB_NOT_ACTIVE = 2'h0,
    LB_ACTIVE = 2'h1,
    LB_SERVICE = 2'h2,
    LB_ACTIVITY = 2'h3
  } lb_state_e;

  // Selection sequencer states
  typedef enum logic [9:0] {
    SEL_IDLE = 10'h001,
    SEL_PRM_RD = 10'h002,
    SEL_PRM_LD = 10'h004,
    SEL_WT_ADDR_DROP = 10'h008,
    SEL_ADDR_LD = 10'h010,
    SEL_WT_CMD = 10'h020,
    SEL_WT_CMD_DROP = 10'h040,
    SEL_STAT_LD = 10'h080,
    SEL_WT_STAT = 10'h100,
    SEL_FINISH = 10'h200
  } sel_state_e;

  // Driver register request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } reg_req_s;

  // Channel inbound lines and straps
  typedef struct packed {
    logic [7:0] busOut;
    logic busOutPar;
    logic addressOut;
    logic selectOut;
    logic selectIn;
    logic commandOut;
    logic serviceOut;
    logic cpuStopped;
    logic simReady;
    logic oneByteMode;
    logic priorityStrap;
    logic testMode;
  } chan_in_s;

  // Channel outbound lines
  typedef struct packed {
    logic [7:0] busIn;
    logic busInPar;
    logic operationalIn;
    logic addressIn;
    logic statusIn;
    logic selectPass;
  } chan_out_s;

  // Odd parity bit for a byte
  function automatic logic oddPar(input logic [7:0] d);
    return ~^d;
  endfunction

  // True when byte and parity bit hold odd parity
  function automatic logic parOk(input logic [7:0] d, input logic p);
    return ^{d, p};
  endfunction

endpackage

// file: design/buffer_ram.sv
`timescale 1ns/100ps
// Simple dual-port memory with registered read data
module buffer_ram #(
  parameter int W = 8,
  parameter int A = 8
) (
  // Clock
  input wire logic clk,
  // Write side
  input wire logic we,
  input wire logic [A-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // Read side
  input wire logic [A-1:0] raddr,
  output logic [W-1:0] rdata
);

  // Storage, not cleared by reset
  logic [W-1:0] mem [2**A];

  // Write, then read out through a register
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// file: verif/channel_adapter_selection_properties.sv
`timescale 1ns/100ps
// Channel tag checks
module channel_adapter_selection_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Channel lines
  input wire chan_adapter_pkg::chan_in_s chanIn,
  input wire chan_adapter_pkg::chan_out_s chanOut,
  // Front panel
  input wire logic onlineLamp
);
  // One clock domain
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=>
    !onlineLamp && !chanOut.operationalIn && !chanOut.statusIn && chanOut.busInPar)
    else $error("reset outputs");
  a_bus_parity: assert property (chanOut.busInPar == ~^chanOut.busIn)
    else $error("bus in parity");
  a_addr_in_op: assert property (chanOut.addressIn |-> chanOut.operationalIn)
    else $error("address in alone");
  a_status_in_op: assert property (chanOut.statusIn |-> chanOut.operationalIn && !chanOut.addressIn)
    else $error("stray status in");
  a_no_pass_sel: assert property (chanOut.operationalIn |-> !chanOut.selectPass)
    else $error("select passed");
  a_op_rise_cause: assert property ($rose(chanOut.operationalIn) |->
    $past(chanIn.addressOut, 2) && ^{$past(chanIn.busOut, 2), $past(chanIn.busOutPar, 2)})
    else $error("bad operational in");
  a_addr_in_rise: assert property ($rose(chanOut.addressIn) |-> !$past(chanIn.addressOut, 2))
    else $error("early address in");
  a_addr_in_fall: assert property ($fell(chanOut.addressIn) |-> $past(chanIn.commandOut, 2))
    else $error("early address in drop");
  a_status_fall: assert property ($fell(chanOut.statusIn) |->
    $past(chanIn.serviceOut, 2) || $past(chanIn.commandOut, 2))
    else $error("status in drop");
  a_op_fall: assert property ($fell(chanOut.operationalIn) |-> !$past(chanIn.selectOut, 2))
    else $error("early operational in drop");
  a_stat_stable: assert property (chanOut.statusIn && $past(chanOut.statusIn) |-> $stable(chanOut.busIn))
    else $error("bus in moved");
  // Main scenarios reached
  c_accepted: cover property ($fell(chanOut.statusIn) && chanIn.serviceOut);
  c_stacked: cover property ($fell(chanOut.statusIn) && chanIn.commandOut);
  c_passed: cover property ($rose(chanOut.selectPass));
endmodule
bind channel_adapter_selection channel_adapter_selection_properties channel_adapter_selection_properties_i (
  .clk(clk), .sys_rst(sys_rst), .chanIn(chanIn), .chanOut(chanOut), .onlineLamp(onlineLamp));

// file: verif/chan_model.sv
`timescale 1ns/100ps
// Channel side of initial selection
module chan_model (
  // Clock
  input wire logic clk,
  // Adapter tags and bus
  input wire chan_adapter_pkg::chan_out_s chanOut,
  // Channel tags and bus
  output logic [7:0] busOut,
  output logic busOutPar,
  output logic addressOut,
  output logic selectOut,
  output logic commandOut,
  output logic serviceOut
);
  // Waits that ran out mid-sequence
  int hangs = 0;
  // Idle levels
  initial begin
    busOut = 8'h00;
    busOutPar = 1'b1;
    addressOut = 1'b0;
    selectOut = 1'b0;
    commandOut = 1'b0;
    serviceOut = 1'b0;
  end
  // Bounded wait for one adapter tag
  task automatic waitTag(input int code, input logic lvl, output logic ok);
    logic [3:0] tags;
    ok = 1'b0;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge clk);
      tags = {chanOut.selectPass, chanOut.statusIn, chanOut.addressIn, chanOut.operationalIn};
      ok = tags[code] === lvl;
    end
  endtask
  // Wait that must succeed
  task automatic step(input int code, input logic lvl);
    logic ok;
    waitTag(code, lvl, ok);
    if (!ok) begin
      hangs++;
    end
  endtask
  // One selection; badPar spoils the address parity
  task automatic runSel(input logic [7:0] addr, input logic badPar, input logic [7:0] cmd,
      input logic stack, input logic holdSel, output logic [7:0] addrSeen,
      output logic [7:0] statSeen, output logic matched, output logic passed);
    @(posedge clk);
    busOut <= addr;
    busOutPar <= ~^addr ^ badPar;
    addressOut <= 1'b1;
    @(posedge clk);
    selectOut <= 1'b1;
    waitTag(3, 1'b1, passed);
    waitTag(0, 1'b1, matched);
    addressOut <= 1'b0;
    if (!matched) begin
      selectOut <= 1'b0;
      busOut <= ~addr;
    end else begin
      step(1, 1'b1);
      addrSeen = chanOut.busIn;
      selectOut <= holdSel;
      busOut <= cmd;
      busOutPar <= ~^cmd;
      commandOut <= 1'b1;
      step(1, 1'b0);
      commandOut <= 1'b0;
      busOut <= ~cmd;
      step(2, 1'b1);
      statSeen = chanOut.busIn;
      commandOut <= stack;
      serviceOut <= !stack;
      step(2, 1'b0);
      commandOut <= 1'b0;
      serviceOut <= 1'b0;
      selectOut <= 1'b0;
      step(0, 1'b0);
    end
  endtask
endmodule

// file: verif/channel_adapter_selection_tb_top.sv
`timescale 1ns/100ps
// Self-checking bench for the selection block
module channel_adapter_selection_tb_top;
  // Clock, reset and straps
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cpuStopped = 1'b1;
  logic testMode = 1'b1;
  // Driver port
  chan_adapter_pkg::reg_req_s regReq = '0;
  logic [7:0] regRdata;
  // Channel side
  chan_adapter_pkg::chan_in_s chanIn;
  chan_adapter_pkg::chan_out_s chanOut;
  logic onlineLamp;
  logic [7:0] busOut;
  logic busOutPar;
  logic addressOut;
  logic selectOut;
  logic commandOut;
  logic serviceOut;
  // Scoreboard
  int failCount = 0;
  int compares = 0;
  logic [7:0] rd;
  logic [7:0] aSeen;
  logic [7:0] sSeen;
  logic matched;
  logic passed;
  // Rows: offset, write value, read-back value
  logic [19:0] rows [4] = '{{4'h2, 8'h0a, 8'h0a}, {4'h4, 8'h05, 8'h05}, {4'h6, 8'h45, 8'h45}, {4'h9, 8'h5a, 8'h00}};
  // Setup writes: offset, value; buffer 2 at address 45, status 40; 46 unassigned
  logic [11:0] cfg [13] = '{{4'h6, 8'h46}, {4'h7, 8'h00}, {4'h2, 8'h02}, {4'h4, 8'h00}, {4'h5, 8'h45},
    {4'h4, 8'h02}, {4'h5, 8'h40}, {4'h6, 8'h45}, {4'h7, 8'h82}, {4'h1, 8'h01}, {4'h4, 8'h03}, {4'h5, 8'h01},
    {4'h1, 8'h03}};
  // 10 MHz clock
  always #50 clk = ~clk;
  // Channel lines and straps
  assign chanIn = '{busOut: busOut, busOutPar: busOutPar, addressOut: addressOut, selectOut: selectOut,
    selectIn: 1'b0, commandOut: commandOut, serviceOut: serviceOut, cpuStopped: cpuStopped,
    simReady: 1'b0, oneByteMode: 1'b0, priorityStrap: 1'b0, testMode: testMode};
  channel_adapter_selection channel_adapter_selection_i (.clk(clk), .sys_rst(sys_rst), .regReq(regReq),
    .regRdata(regRdata), .chanIn(chanIn), .chanOut(chanOut), .onlineLamp(onlineLamp));
  chan_model chan_model_i (.clk(clk), .chanOut(chanOut), .busOut(busOut), .busOutPar(busOutPar),
    .addressOut(addressOut), .selectOut(selectOut), .commandOut(commandOut), .serviceOut(serviceOut));
  // Counts a comparison, reports a mismatch
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle write strobe
  task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge clk);
    regReq.write <= 1'b0;
  endtask
  // One-cycle read strobe, data in the next cycle
  task automatic regRead(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    regReq <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
    @(posedge clk);
    regReq.read <= 1'b0;
    @(posedge clk);
    d = regRdata;
  endtask
  // Bounded poll of one status bit
  task automatic pollStatus(input int b, input logic lvl);
    for (int i = 0; i < 50; i++) begin
      regRead(chan_adapter_pkg::REG_STATUS, rd);
      if (rd[b] === lvl) begin
        return;
      end
    end
    failCount++;
    $display("wrong value status bit expected %b seen %b", lvl, rd[b]);
    finishTest();
  endtask
  // Counts and verdict, then end
  task automatic finishTest();
    $display("Compares %0d, mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    finishTest();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check("lamp", 8'h00, {7'h00, onlineLamp}); // Dark after reset
    for (int i = 0; i < 4; i++) begin
      regWrite(rows[i][19:16], rows[i][15:8]);
      regRead(rows[i][19:16], rd);
      check("register", rows[i][7:0], rd);
    end
    for (int i = 0; i < 10; i++) begin
      regWrite(cfg[i][11:8], cfg[i][7:0]); // Configure, ask for online
    end
    regRead(chan_adapter_pkg::REG_LB_STATE, rd);
    check("buffer state", 8'h01, rd); // Configured is active
    repeat (10) @(posedge clk);
    regRead(chan_adapter_pkg::REG_STATUS, rd);
    check("status", 8'h01, rd); // No simulator, offline
    testMode <= 1'b0;
    pollStatus(chan_adapter_pkg::ST_ONLINE, 1'b1); // CPU stopped
    regRead(chan_adapter_pkg::REG_STATUS, rd);
    check("status", 8'h02, rd); // Online, busy cleared
    check("lamp", 8'h01, {7'h00, onlineLamp}); // Lit when online
    for (int i = 0; i < 2; i++) begin
      chan_model_i.runSel(8'h45 + i[7:0], i == 0, 8'h02, 1'b0, 1'b0, aSeen, sSeen, matched, passed);
      check("select passed", 8'h01, {7'h00, passed & !matched});
    end
    chan_model_i.runSel(8'h45, 1'b0, chan_adapter_pkg::CMD_NOP, 1'b0, 1'b0, aSeen, sSeen, matched, passed);
    check("address returned", 8'h45, aSeen); // Byte zero on bus
    check("no-op status", 8'h0c, sSeen); // Channel end and device end
    chan_model_i.runSel(8'h45, 1'b0, 8'h01, 1'b1, 1'b0, aSeen, sSeen, matched, passed);
    check("initial status", 8'h40, sSeen); // Status from byte two
    regRead(chan_adapter_pkg::REG_STATUS, rd);
    check("status", 8'h02, rd); // Silent so far
    chan_model_i.runSel(8'h45, 1'b0, chan_adapter_pkg::CMD_TEST_IO, 1'b0, 1'b1, aSeen, sSeen, matched, passed);
    regRead(chan_adapter_pkg::REG_STATUS, rd);
    check("status", 8'h06, rd); // Notified
    regRead(chan_adapter_pkg::REG_LB_STATE, rd);
    check("buffer state", 8'h02, rd); // Service required
    regRead(chan_adapter_pkg::REG_FIFO, rd);
    check("queue", 8'h82, rd); // Buffer queued
    regWrite(chan_adapter_pkg::REG_CTRL_IDX, {4'h0, chan_adapter_pkg::CB_COMMAND});
    regRead(chan_adapter_pkg::REG_CTRL_DATA, rd);
    check("command byte", 8'h01, rd); // Test I/O not stored
    regWrite(chan_adapter_pkg::REG_CTRL_IDX, {4'h0, chan_adapter_pkg::CB_CHAN_CTRL});
    regRead(chan_adapter_pkg::REG_CTRL_DATA, rd);
    check("control word", 8'h21, rd & 8'h21);
    for (int i = 10; i < 13; i++) begin
      regWrite(cfg[i][11:8], cfg[i][7:0]); // Byte 3, then initiate
    end
    repeat (20) @(posedge clk);
    regRead(chan_adapter_pkg::REG_LB_STATE, rd);
    check("buffer state", 8'h01, rd); // Device end, active
    regWrite(chan_adapter_pkg::REG_HOST_CMD, {5'h00, chan_adapter_pkg::HC_OFFLINE}); // Issued while idle
    pollStatus(chan_adapter_pkg::ST_ONLINE, 1'b0); // Offline once all idle
    check("partner waits", 8'h00, chan_model_i.hangs[7:0]);
    finishTest();
  end
endmodule
